/* File: adc_ctl_pkg.sv */
/*
  Shared constants for the converter control block: register map, field
  positions, channel codes and timing counts.
  Assumes a 100 MHz system clock and a 32-bit Avalon-MM register bus.
*/
package adc_ctl_pkg;

  // Clock and timing
  localparam int CLK_PERIOD_NS  = 10;      // System clock period
  localparam int SAMPLE_TIME_NS = 200;     // Sample-and-hold window per conversion
  localparam int BIT_TIME_NS    = 100;     // Settling time per approximation step
  localparam int SAMPLE_CYCLES  = (SAMPLE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int BIT_CYCLES     = (BIT_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CNT_W          = 8;       // Width of the step timer

  // Converter geometry
  localparam int RES_W = 10;               // Result width
  localparam int CH_W  = 5;                // Channel-select width

  // Variant options
  localparam bit LARGE_VARIANT = 1'b1;     // 1: pins 0..11, 0: pins 0..7
  localparam bit LOW_V_VARIANT = 1'b0;     // 1: a 4x converter level request maps to off; the DAC level is passed
  localparam logic [CH_W-1:0] NUM_PINS_LARGE = 5'h0c;
  localparam logic [CH_W-1:0] NUM_PINS_SMALL = 5'h08;

  // Internal channel codes
  localparam logic [CH_W-1:0] CH_TEMP   = 5'h1d; // Reserved temperature channel
  localparam logic [CH_W-1:0] CH_DAC    = 5'h1e; // DAC output
  localparam logic [CH_W-1:0] CH_FIXREF = 5'h1f; // Fixed-reference buffer

  // Register byte offsets
  localparam logic [4:0] OFS_CTRL_FIRST  = 5'h00;
  localparam logic [4:0] OFS_CTRL_SECOND = 5'h04;
  localparam logic [4:0] OFS_FIXED_REF   = 5'h08;
  localparam logic [4:0] OFS_RESULT_HIGH = 5'h0c;
  localparam logic [4:0] OFS_RESULT_LOW  = 5'h10;
  localparam logic [4:0] OFS_IRQ_STATUS  = 5'h14;
  localparam logic [4:0] OFS_IRQ_MASK    = 5'h18;

  // Control-first fields
  localparam int CF_ON   = 0;              // Converter enable
  localparam int CF_GO   = 1;              // Go / done
  localparam int CF_CH_L = 2;              // Channel select, bits 6:2

  // Control-second fields
  localparam int CS_PREF_L = 0;            // Positive reference, bits 1:0
  localparam int CS_NREF   = 2;            // Negative reference

  // Positive reference encodings
  localparam logic [1:0] PREF_SUPPLY = 2'h0;
  localparam logic [1:0] PREF_PIN    = 2'h2;
  localparam logic [1:0] PREF_FIXED  = 2'h3;

  // Fixed-reference control fields
  localparam int FR_EN    = 7;
  localparam int FR_RDY   = 6;
  localparam int FR_TEMP_SENSOR_ENABLE  = 5;
  localparam int FR_TEMP_SENSOR_RANGE = 4;
  localparam int FR_CDA_L = 2;             // Bits 3:2
  localparam int FR_CONV_L = 0;            // Bits 1:0

  // Fixed-reference level codes
  localparam logic [1:0] LVL_OFF = 2'h0;
  localparam logic [1:0] LVL_1X  = 2'h1;
  localparam logic [1:0] LVL_2X  = 2'h2;
  localparam logic [1:0] LVL_4X  = 2'h3;

  // Interrupt status bit
  localparam int IRQ_DONE = 0;

  // Reset values
  localparam logic [7:0] RST_BYTE = 8'h00;

endpackage : adc_ctl_pkg

/* File: sar_if.sv */
/*
  Carrier between the register front end and the approximation engine.
  Assumes both ends share one clock.
*/
`timescale 1ns/1ps
interface sar_if;
  import adc_ctl_pkg::*;
  logic             start;                 // Pulse: begin sample and convert
  logic             abort;                 // Pulse: stop and store partial code
  logic             cmp_above;             // Analog input at or above trial code
  logic             sample;                // Sample-and-hold closed
  logic [RES_W-1:0] trial;                 // Code presented to the internal DAC
  logic             done;                  // Pulse: full conversion finished
  logic             stored;                // Pulse: result is valid to load
  logic [RES_W-1:0] result;                // Finished or partial code

  modport ctrl (output start, output abort, output cmp_above,
                input sample, input trial, input done, input stored, input result);
  modport engine (input start, input abort, input cmp_above,
                  output sample, output trial, output done, output stored, output result);
endinterface : sar_if

/* File: sar_engine.sv */
/*
  Successive-approximation sequencer: samples, then decides one bit per step.
  Assumes an external comparator answers within one step time.
*/
`timescale 1ns/1ps
module sar_engine (
  input  wire logic clock,
  input  wire logic rst,
  sar_if.engine     sar
);
  import adc_ctl_pkg::*;

  typedef enum logic [1:0] {IDLE, SAMPLE, CONVERT} sar_state_e;

  typedef struct packed {
    sar_state_e       state;               // Sequencer state
    logic [CNT_W-1:0] cnt;                 // Step timer
    logic [3:0]       idx;                 // Bit under trial
    logic [RES_W-1:0] trial;               // Decided bits plus trial bit
    logic [RES_W-1:0] result;              // Last stored code
    logic             sample;
    logic             done;
    logic             stored;
  } sar_s;

  sar_s st_r;
  sar_s st_nxt;

  // Next-state logic
  always_comb begin
    logic fill;                            // Value of the last decided bit
    st_nxt = st_r;
    fill = 1'b0;
    st_nxt.done = 1'b0;
    st_nxt.stored = 1'b0;
    unique case (st_r.state)
      IDLE: begin
        if (sar.start) begin
          st_nxt.state = SAMPLE;
          st_nxt.sample = 1'b1;
          st_nxt.cnt = CNT_W'(SAMPLE_CYCLES - 1);
        end
      end
      SAMPLE: begin
        if (st_r.cnt == '0) begin
          // Open the hold and try the top bit first
          st_nxt.state = CONVERT;
          st_nxt.sample = 1'b0;
          st_nxt.idx = 4'(RES_W - 1);
          st_nxt.trial = RES_W'(1) << (RES_W - 1);
          st_nxt.cnt = CNT_W'(BIT_CYCLES - 1);
        end else begin
          st_nxt.cnt = st_r.cnt - 1'b1;
        end
      end
      CONVERT: begin
        if (st_r.cnt == '0) begin
          if (!sar.cmp_above) begin
            st_nxt.trial[st_r.idx] = 1'b0; // Trial too high, drop the bit
          end
          if (st_r.idx == '0) begin
            st_nxt.state = IDLE;
            st_nxt.result = st_nxt.trial;
            st_nxt.done = 1'b1;
            st_nxt.stored = 1'b1;
          end else begin
            st_nxt.idx = st_r.idx - 1'b1;
            st_nxt.trial[st_r.idx - 1'b1] = 1'b1;
            st_nxt.cnt = CNT_W'(BIT_CYCLES - 1);
          end
        end else begin
          st_nxt.cnt = st_r.cnt - 1'b1;
        end
      end
    endcase
    // Abort keeps decided bits; undecided ones copy the last decided bit
    if (sar.abort && st_r.state != IDLE) begin
      if (st_r.state == CONVERT && st_r.idx != 4'(RES_W - 1)) begin
        fill = st_r.trial[st_r.idx + 1'b1];
      end
      st_nxt.result = st_r.trial;
      for (int i = 0; i < RES_W; i++) begin
        if (st_r.state == SAMPLE || i <= int'(st_r.idx)) begin
          st_nxt.result[i] = fill;
        end
      end
      st_nxt.state = IDLE;
      st_nxt.sample = 1'b0;
      st_nxt.stored = 1'b1;
      st_nxt.done = 1'b0;
    end
  end

  // State register
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      st_r <= '{state: IDLE, default: '0};
    end else begin
      st_r <= st_nxt;
    end
  end

  assign sar.sample = st_r.sample;
  assign sar.trial  = st_r.trial;
  assign sar.done   = st_r.done;
  assign sar.stored = st_r.stored;
  assign sar.result = st_r.result;

endmodule : sar_engine

/* File: adc_channel_ref_temp_control.sv */
/*
  Converter control block: Avalon-MM register file, channel and reference
  routing, temperature sensor control, result and interrupt logic.
  Assumes analog muxes, references and the comparator sit outside and are
  steered by the routing outputs; inputs are synchronous to clock.
*/
// Local design decisions: the address map and the Avalon-MM register port.
//
// Contract
// - Convert each sample to 10-bit result pair.
// - Conversion done raises interrupt, wakes sleep.
// - Up to 14 inputs: pins, DAC, reference.
// - Channel field routes source to sample-hold.
// - Positive reference: pin, supply, fixed levels.
// - Negative reference: pin or ground.
// - Bit 5 powers temperature sensor.
// - Bit 4 selects sensor high range.
// - Sensor wired to reserved converter channel.
// - Fixed-reference register field layout, high to low.
// - Ready flag reads 1 only when ready.
// - Converter level codes off, 1x, 2x, 4x.
// - Finish clears go, sets flag, loads result.
`timescale 1ns/1ps
module adc_channel_ref_temp_control (
  input  wire  logic                         clock,
  input  wire  logic                         rst,
  // Avalon-MM slave
  input  wire  logic [4:0]                   address,
  input  wire  logic                         read,
  input  wire  logic                         write,
  input  wire  logic [31:0]                  writedata,
  input  wire  logic [3:0]                   byteenable,
  output logic       [31:0]                  readdata,
  output logic                               waitrequest,
  // Analog side
  input  wire  logic                         cmp_above,
  input  wire  logic                         fixed_ref_ready,
  output logic                               sample_hold,
  output logic       [adc_ctl_pkg::RES_W-1:0] trial_code,
  output logic       [adc_ctl_pkg::CH_W-1:0] channel_route,
  output logic                               channel_route_en,
  output logic       [1:0]                   pos_ref_route,
  output logic                               neg_ref_route,
  output logic                               fixed_ref_enable,
  output logic                               temp_sensor_enable,
  output logic                               temp_sensor_range,
  output logic       [1:0]                   cmp_dac_ref_level,
  output logic       [1:0]                   conv_ref_level,
  output logic                               conv_irq
);
  import adc_ctl_pkg::*;

  typedef struct packed {
    logic             wait_r;              // Waitrequest level
    logic [31:0]      rdata;               // Read data holding register
    logic             conv_on;             // Converter enable
    logic             go;                  // Go / done
    logic [CH_W-1:0]  channel_select;      // Live channel field
    logic [1:0]       pos_ref_select;
    logic             neg_ref_select;
    logic [CH_W-1:0]  act_channel;         // Copies held for a running conversion
    logic [1:0]       act_pos_ref;
    logic             act_neg_ref;
    logic [7:0]       fixed_ref_control;   // Writable fields only
    logic [7:0]       result_high;
    logic [7:0]       result_low;
    logic [7:0]       irq_status;
    logic [7:0]       irq_mask;
    logic             start;               // Pulse to the engine
    logic             abort;               // Pulse to the engine
    logic [CH_W-1:0]  ch_route;
    logic             ch_route_en;
    logic [1:0]       pref_route;
    logic             nref_route;
    logic [1:0]       conv_lvl;
    logic             irq;
  } ctl_s;

  ctl_s  st_r;                             // Registered state
  ctl_s  st_nxt;                           // Next state
  sar_if sar ();                           // Link to the engine

  // Channel exists on this variant; internal sources always do
  function automatic logic chan_ok(input logic [CH_W-1:0] ch);
    logic [CH_W-1:0] npins;
    npins = LARGE_VARIANT ? NUM_PINS_LARGE : NUM_PINS_SMALL;
    return (ch < npins) || (ch == CH_TEMP) || (ch == CH_DAC) || (ch == CH_FIXREF);
  endfunction : chan_ok

  // Map a level request onto what the variant can provide
  function automatic logic [1:0] lvl_map(input logic [1:0] lvl);
    return (LOW_V_VARIANT && lvl == LVL_4X) ? LVL_OFF : lvl;
  endfunction : lvl_map

  // Register read mux
  function automatic logic [31:0] reg_read(input logic [4:0] ofs, input ctl_s s, input logic rdy);
    logic [31:0] d;
    d = '0;
    unique case (ofs)
      OFS_CTRL_FIRST: begin
        d[CF_ON] = s.conv_on;
        d[CF_GO] = s.go;
        d[CF_CH_L +: CH_W] = s.channel_select;
      end
      OFS_CTRL_SECOND: begin
        d[CS_PREF_L +: 2] = s.pos_ref_select;
        d[CS_NREF] = s.neg_ref_select;
      end
      OFS_FIXED_REF: begin
        d[7:0] = s.fixed_ref_control;
        d[FR_RDY] = rdy;
      end
      OFS_RESULT_HIGH: d[7:0] = s.result_high;
      OFS_RESULT_LOW:  d[7:0] = s.result_low;
      OFS_IRQ_STATUS:  d[7:0] = s.irq_status;
      OFS_IRQ_MASK:    d[7:0] = s.irq_mask;
      default:         d = '0;             // Unmapped reads as zero
    endcase
    return d;
  endfunction : reg_read

  // Next-state logic: bus, conversion control, routing, interrupt
  always_comb begin
    logic        commit;                   // Write takes effect this edge
    logic [7:0]  wb;                       // Low write byte
    logic        ready_flag;
    st_nxt = st_r;
    st_nxt.start = 1'b0;
    st_nxt.abort = 1'b0;
    wb = writedata[7:0];
    commit = write && !st_r.wait_r && byteenable[0];
    ready_flag = fixed_ref_ready && st_r.fixed_ref_control[FR_EN];

    // One wait state per access; read data is captured on the first cycle, write data on the second
    if ((read || write) && st_r.wait_r) begin
      st_nxt.wait_r = 1'b0;
      st_nxt.rdata = read ? reg_read(address, st_r, ready_flag) : '0;
    end else begin
      st_nxt.wait_r = 1'b1;
    end

    // Engine results; a finished conversion ends go
    if (sar.stored) begin
      st_nxt.result_high = {6'h00, sar.result[RES_W-1:8]};
      st_nxt.result_low = sar.result[7:0];
    end
    if (sar.done) begin
      st_nxt.go = 1'b0;
    end

    // Register writes
    if (commit) begin
      unique case (address)
        OFS_CTRL_FIRST: begin
          st_nxt.conv_on = wb[CF_ON];
          st_nxt.channel_select = wb[CF_CH_L +: CH_W];
          if (wb[CF_GO] && wb[CF_ON] && st_r.conv_on && !st_r.go) begin
            // Start only when already on, so power-up and go never coincide
            st_nxt.go = 1'b1;
            st_nxt.start = 1'b1;
            st_nxt.act_channel = wb[CF_CH_L +: CH_W];
            st_nxt.act_pos_ref = st_r.pos_ref_select;
            st_nxt.act_neg_ref = st_r.neg_ref_select;
          end else if (st_r.go && (!wb[CF_GO] || !wb[CF_ON])) begin
            // Software stop or power-down ends the conversion early
            st_nxt.go = 1'b0;
            st_nxt.abort = 1'b1;
          end
        end
        OFS_CTRL_SECOND: begin
          st_nxt.pos_ref_select = wb[CS_PREF_L +: 2];
          st_nxt.neg_ref_select = wb[CS_NREF];
        end
        OFS_FIXED_REF: begin
          st_nxt.fixed_ref_control = wb & ~(8'h01 << FR_RDY);
        end
        OFS_IRQ_STATUS: st_nxt.irq_status = st_r.irq_status & ~wb;
        OFS_IRQ_MASK:   st_nxt.irq_mask = wb;
        default:        st_nxt.irq_mask = st_nxt.irq_mask; // Unmapped or read-only: ignored
      endcase
    end

    // Completion sets the flag after any clear, so the event is kept
    if (sar.done) begin
      st_nxt.irq_status[IRQ_DONE] = 1'b1;
    end

    // Routing: held copies while running, live fields otherwise
    if (st_nxt.go) begin
      st_nxt.ch_route = st_nxt.act_channel;
      st_nxt.pref_route = st_nxt.act_pos_ref;
      st_nxt.nref_route = st_nxt.act_neg_ref;
    end else begin
      st_nxt.ch_route = st_nxt.channel_select;
      st_nxt.pref_route = st_nxt.pos_ref_select;
      st_nxt.nref_route = st_nxt.neg_ref_select;
    end
    st_nxt.ch_route_en = st_nxt.conv_on && chan_ok(st_nxt.ch_route);
    st_nxt.conv_lvl = lvl_map(st_nxt.fixed_ref_control[FR_CONV_L +: 2]);

    // Level interrupt; it doubles as the wake request from sleep
    st_nxt.irq = |(st_nxt.irq_status & st_nxt.irq_mask);
  end

  // State register
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      st_r <= '{wait_r: 1'b1, default: '0};
    end else begin
      st_r <= st_nxt;
    end
  end

  // Engine drive
  assign sar.start     = st_r.start;
  assign sar.abort     = st_r.abort;
  assign sar.cmp_above = cmp_above;

  sar_engine u_engine (
    .clock (clock),
    .rst   (rst),
    .sar   (sar)
  );

  // Outputs, all from flip-flops
  assign readdata           = st_r.rdata;
  assign waitrequest        = st_r.wait_r;
  assign sample_hold        = sar.sample;
  assign trial_code         = sar.trial;
  assign channel_route      = st_r.ch_route;
  assign channel_route_en   = st_r.ch_route_en;
  assign pos_ref_route      = st_r.pref_route;
  assign neg_ref_route      = st_r.nref_route;
  assign fixed_ref_enable   = st_r.fixed_ref_control[FR_EN];
  assign temp_sensor_enable = st_r.fixed_ref_control[FR_TEMP_SENSOR_ENABLE];
  assign temp_sensor_range  = st_r.fixed_ref_control[FR_TEMP_SENSOR_RANGE];
  assign cmp_dac_ref_level  = st_r.fixed_ref_control[FR_CDA_L +: 2];
  assign conv_ref_level     = st_r.conv_lvl;
  assign conv_irq           = st_r.irq;

endmodule : adc_channel_ref_temp_control

/* File: adc_ctl_monitor.sv */
/* Port checker for the converter control block.
   Assumes one clock domain and the shared package constants. */
`timescale 1ns/1ps
module adc_ctl_monitor
  import adc_ctl_pkg::*;
(
  input wire logic             clock,
  input wire logic             rst,
  input wire logic             read,
  input wire logic             write,
  input wire logic [31:0]      readdata,
  input wire logic             waitrequest,
  input wire logic             sample_hold,
  input wire logic [RES_W-1:0] trial_code,
  input wire logic [CH_W-1:0]  channel_route,
  input wire logic             channel_route_en,
  input wire logic [1:0]       pos_ref_route,
  input wire logic             neg_ref_route,
  input wire logic             fixed_ref_enable,
  input wire logic             temp_sensor_enable,
  input wire logic             temp_sensor_range,
  input wire logic [1:0]       cmp_dac_ref_level,
  input wire logic [1:0]       conv_ref_level
);
  logic [7:0] sh_cnt_r; // Length of the current sample window

  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  // Counts sample cycles; a counter avoids a long repetition
  always_ff @(posedge clock or posedge rst) begin
    if (rst) sh_cnt_r <= 8'h00;
    else if (sample_hold) sh_cnt_r <= sh_cnt_r + 8'h01;
    else sh_cnt_r <= 8'h00;
  end

  sequence s_taken;
    (read || write) && waitrequest;
  endsequence
  sequence s_answer;
    !waitrequest ##1 waitrequest;
  endsequence

  a_bus_answer_once: assert property (s_taken |=> s_answer) else $error("bus answer not one cycle");
  a_no_spurious_ack: assert property (!read && !write |=> waitrequest) else $error("ack without request");
  a_readdata_holds: assert property ($changed(readdata) |-> !waitrequest) else $error("readdata moved");
  a_sample_width: assert property ($fell(sample_hold) |-> sh_cnt_r == 8'h14) else $error("sample window length");
  a_first_trial: assert property ($fell(sample_hold) |-> ##[0:1] trial_code == 10'h200) else $error("first trial");
  a_bit_step_hold: assert property ($changed(trial_code) && trial_code != 10'h000 |=> $stable(trial_code) [*8])
    else $error("bit step too short");
  a_route_frozen: assert property (sample_hold && $past(sample_hold) |->
    $stable({channel_route, pos_ref_route, neg_ref_route})) else $error("route moved in sample");
  a_route_legal: assert property (channel_route_en |-> channel_route < NUM_PINS_LARGE || channel_route >= CH_TEMP)
    else $error("route to missing channel");
  a_copy_on_write: assert property ($changed({fixed_ref_enable, temp_sensor_enable, temp_sensor_range,
    cmp_dac_ref_level, conv_ref_level}) |-> $past(write) || $past(write, 2)) else $error("field moved alone");
endmodule : adc_ctl_monitor

bind adc_channel_ref_temp_control adc_ctl_monitor mon_u (.clock(clock), .rst(rst), .read(read), .write(write),
  .readdata(readdata), .waitrequest(waitrequest), .sample_hold(sample_hold), .trial_code(trial_code),
  .channel_route(channel_route), .channel_route_en(channel_route_en), .pos_ref_route(pos_ref_route),
  .neg_ref_route(neg_ref_route), .fixed_ref_enable(fixed_ref_enable), .temp_sensor_enable(temp_sensor_enable),
  .temp_sensor_range(temp_sensor_range), .cmp_dac_ref_level(cmp_dac_ref_level), .conv_ref_level(conv_ref_level));

/* File: analog_model.sv */
/* Analog side model: ideal comparator and a settling fixed reference.
   Assumes the bench sets the input level between conversions. */
`timescale 1ns/1ps
module analog_model
  import adc_ctl_pkg::*;
(
  input wire logic             clock,
  input wire logic             rst,
  input wire logic [RES_W-1:0] level,
  input wire logic [RES_W-1:0] trial_code,
  input wire logic             fixed_ref_enable,
  output logic                 cmp_above,
  output logic                 fixed_ref_ready
);
  logic [2:0] settle_r; // Reference settling count

  // Ideal comparator, so a full conversion returns the level itself
  assign cmp_above = (level >= trial_code);

  // Ready only after settling; drops at once when disabled
  always_ff @(posedge clock or posedge rst) begin
    if (rst) settle_r <= 3'h0;
    else if (!fixed_ref_enable) settle_r <= 3'h0;
    else if (settle_r != 3'h7) settle_r <= settle_r + 3'h1;
  end
  assign fixed_ref_ready = (settle_r == 3'h7);
endmodule : analog_model

/* File: tb_top.sv */
/* Self-checking bench: register, routing and conversion scenarios.
   Assumes the analog model stands in for comparator and reference. */
`timescale 1ns/1ps
`define CHK(nm, ex, sn) begin compares++; if ((sn) !== (ex)) begin failures++; \
  $display("ERROR %s expected %0h seen %0h", nm, ex, sn); end end
module tb_top;
  import adc_ctl_pkg::*;
  logic             clock, rst, read, write, waitrequest, cmp_above, fixed_ref_ready, sample_hold;
  logic             channel_route_en, neg_ref_route, fixed_ref_enable, temp_sensor_enable, temp_sensor_range;
  logic             conv_irq;
  logic [4:0]       address;
  logic [31:0]      writedata, readdata, rd;
  logic [3:0]       byteenable;
  logic [RES_W-1:0] trial_code, level;
  logic [CH_W-1:0]  channel_route;
  logic [1:0]       pos_ref_route, cmp_dac_ref_level, conv_ref_level;
  int               failures, compares;

  adc_channel_ref_temp_control dut_u (.clock(clock), .rst(rst), .address(address), .read(read), .write(write),
    .writedata(writedata), .byteenable(byteenable), .readdata(readdata), .waitrequest(waitrequest),
    .cmp_above(cmp_above), .fixed_ref_ready(fixed_ref_ready), .sample_hold(sample_hold), .trial_code(trial_code),
    .channel_route(channel_route), .channel_route_en(channel_route_en), .pos_ref_route(pos_ref_route),
    .neg_ref_route(neg_ref_route), .fixed_ref_enable(fixed_ref_enable), .temp_sensor_enable(temp_sensor_enable),
    .temp_sensor_range(temp_sensor_range), .cmp_dac_ref_level(cmp_dac_ref_level),
    .conv_ref_level(conv_ref_level), .conv_irq(conv_irq));
  analog_model ana_u (.clock(clock), .rst(rst), .level(level), .trial_code(trial_code),
    .fixed_ref_enable(fixed_ref_enable), .cmp_above(cmp_above), .fixed_ref_ready(fixed_ref_ready));

  // 100 MHz clock
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  // One Avalon access; holds until waitrequest is sampled low
  task automatic bus(input logic [4:0] a, input logic wr, input logic [7:0] d, input logic [3:0] be);
    int n;
    n = 0;
    @(posedge clock);
    address <= a;
    writedata <= {24'h000000, d};
    byteenable <= be;
    read <= !wr;
    write <= wr;
    do begin
      @(posedge clock);
      n++;
    end while (waitrequest !== 1'b0 && n < 50);
    if (n >= 50) failures++;
    rd = readdata;
    read <= 1'b0;
    write <= 1'b0;
  endtask : bus

  // Read one register and compare its low byte
  task automatic rchk(input logic [4:0] a, input logic [7:0] ex);
    bus(a, 1'b0, 8'h00, 4'h1);
    `CHK($sformatf("register %0h", a), ex, rd[7:0])
  endtask : rchk

  // Select, wait the acquisition delay, start, retarget mid-run, then check completion
  task automatic conv(input logic [4:0] ch, input logic [9:0] lv, input logic irq_ex, input int acq);
    int n;
    n = 0;
    level <= lv;
    bus(OFS_CTRL_FIRST, 1'b1, {1'b0, ch, 2'h1}, 4'h1);
    repeat (acq) @(posedge clock);
    bus(OFS_CTRL_FIRST, 1'b1, {1'b0, ch, 2'h3}, 4'h1);
    bus(OFS_CTRL_FIRST, 1'b1, {1'b0, ch ^ 5'h01, 2'h3}, 4'h1);
    @(negedge clock);
    `CHK("channel_route", ch, channel_route)
    do begin
      bus(OFS_IRQ_STATUS, 1'b0, 8'h00, 4'h1);
      n++;
    end while (rd[IRQ_DONE] !== 1'b1 && n < 80);
    rchk(OFS_RESULT_HIGH, {6'h00, lv[9:8]});
    rchk(OFS_RESULT_LOW, lv[7:0]);
    rchk(OFS_CTRL_FIRST, {1'b0, ch ^ 5'h01, 2'h1});
    `CHK("channel_route", ch ^ 5'h01, channel_route)
    `CHK("conv_irq", irq_ex, conv_irq)
    bus(OFS_IRQ_STATUS, 1'b1, 8'h01, 4'h1);
    rchk(OFS_IRQ_STATUS, 8'h00);
    `CHK("conv_irq", 1'b0, conv_irq)
  endtask : conv

  // Verdict; the only exit of the run
  task automatic report_and_stop();
    if (failures == 0 && compares > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : report_and_stop

  // Watchdog against a hung handshake
  initial begin
    repeat (60000) @(posedge clock);
    failures++;
    report_and_stop();
  end

  // Main sequence
  initial begin
    rst = 1'b1;
    read = 1'b0;
    write = 1'b0;
    address = 5'h00;
    writedata = 32'h00000000;
    byteenable = 4'h0;
    level = 10'h000;
    failures = 0;
    compares = 0;
    repeat (16) @(posedge clock);
    rst <= 1'b0;
    for (int a = 0; a < 8; a++) rchk(5'(a * 4), RST_BYTE);
    bus(OFS_FIXED_REF, 1'b1, 8'hbf, 4'h1);
    @(negedge clock);
    `CHK("fixed_ref_bits", 5'h1f, {fixed_ref_enable, temp_sensor_enable, temp_sensor_range, cmp_dac_ref_level})
    `CHK("conv_ref_level", LVL_4X, conv_ref_level)
    rchk(OFS_FIXED_REF, 8'hbf);
    repeat (10) @(posedge clock);
    rchk(OFS_FIXED_REF, 8'hff);
    for (int l = 0; l < 4; l++) begin
      bus(OFS_FIXED_REF, 1'b1, {6'h20, 2'(l)} | {4'h0, 2'(l), 2'h0}, 4'h1);
      @(negedge clock);
      `CHK("levels", {2'(l), 2'(l)}, {cmp_dac_ref_level, conv_ref_level})
      `CHK("temp_sensor_enable", 1'b0, temp_sensor_enable)
    end
    bus(OFS_FIXED_REF, 1'b1, 8'h00, 4'h0);
    rchk(OFS_FIXED_REF, 8'hcf);
    bus(OFS_FIXED_REF, 1'b1, 8'h20, 4'h1);
    rchk(OFS_FIXED_REF, 8'h20);
    for (int i = 0; i < 4; i++) begin
      bus(OFS_CTRL_SECOND, 1'b1, {5'h00, 3'(i)} ^ 8'h04, 4'h1);
      @(negedge clock);
      `CHK("pos_ref_route", 2'(i), pos_ref_route)
      `CHK("neg_ref_route", ~i[2], neg_ref_route)
    end
    for (int c = 0; c < 32; c++) begin
      bus(OFS_CTRL_FIRST, 1'b1, {1'b0, 5'(c), 2'h1}, 4'h1);
      @(negedge clock);
      `CHK("channel_route_en", (c < 12 || c >= 29), channel_route_en)
      if (c < 12 || c >= 29) `CHK("channel_route", 5'(c), channel_route)
    end
    bus(OFS_CTRL_FIRST, 1'b1, 8'h00, 4'h1);
    bus(OFS_CTRL_FIRST, 1'b1, 8'h0f, 4'h1);
    rchk(OFS_CTRL_FIRST, 8'h0d);
    `CHK("sample_hold", 1'b0, sample_hold)
    bus(OFS_IRQ_MASK, 1'b1, 8'h01, 4'h1);
    conv(5'h03, 10'h2c9, 1'b1, 20);
    bus(OFS_IRQ_MASK, 1'b1, 8'h00, 4'h1);
    conv(CH_DAC, 10'h3ff, 1'b0, 20);
    conv(CH_TEMP, 10'h155, 1'b0, 20000);
    level <= 10'h2a0;
    bus(OFS_CTRL_FIRST, 1'b1, 8'h2f, 4'h1);
    while (sample_hold !== 1'b1 && compares < 9999) @(posedge clock);
    while (sample_hold === 1'b1) @(posedge clock);
    repeat (30) @(posedge clock);
    bus(OFS_CTRL_FIRST, 1'b1, 8'h2d, 4'h1);
    repeat (4) @(posedge clock);
    rchk(OFS_RESULT_HIGH, 8'h02);
    rchk(OFS_RESULT_LOW, 8'hff);
    rchk(OFS_IRQ_STATUS, 8'h00);
    report_and_stop();
  end
endmodule : tb_top
